// file: logic/scg_pkg.sv
// Purpose: Constants, types and decode helpers of the serial command gateway.
// Assumes: A 100 MHz register clock and a 9600 baud 8N1 serial link without handshake.
// Notes:   Register offsets are byte addresses on a 32-bit APB.
//
// What this block does
// - At the 2D code and RFID positions a telegram is STX, payload, CR, LF, with no acknowledgment.
// - At the hand-held scanner position a telegram is payload, CR, LF, with no STX.
// - At the hand-held scanner position command mode is not offered and no command is sent.
// - Command mode is active only while bit 0 of control byte 0 is one.
// - At position 6 control bit 1 sends DC2 to open and DC4 to close the gate, and bit 0 sends the version query.
// - At position 7 control bit 0 sends 'V' and control bit 1 sends '+' to trigger an image.
// - At position 9 control bit 0 sends 'v', and control bit 1 sends '+' to open and '-' to close the gate.
// - At position 9 control bit 14 sends 'R' to restore defaults and control bit 15 sends 'H' to restart.
// - For the bridged UHF variant at position 9 the version query and parameter reset are never sent.
package scg_pkg;

  localparam int CLK_FREQ_HZ = 100_000_000;
  localparam int BAUD_RATE   = 9600;
  localparam int BIT_CYCLES  = CLK_FREQ_HZ / BAUD_RATE;
  localparam logic [3:0] UART_FRAME_BITS = 4'hA;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMD    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  localparam int CTRL_CMD_MODE_BIT = 0;
  localparam int CTRL_UHF_BIT      = 1;
  localparam int CMD_VER_BIT       = 0;
  localparam int CMD_GATE_BIT      = 1;
  localparam int CMD_RESET_BIT     = 14;
  localparam int CMD_RESTART_BIT   = 15;
  localparam int STAT_BUSY_BIT     = 4;
  localparam int STAT_TX_BIT       = 5;
  localparam int STAT_COUNT_LSB    = 8;

  localparam logic [1:0]  CTRL_RESET  = 2'h0;
  localparam logic [15:0] CMD_RESET   = 16'h0000;

  localparam logic [3:0] POS_2D_GATE  = 4'h6;
  localparam logic [3:0] POS_2D_TRIG  = 4'h7;
  localparam logic [3:0] POS_HANDHELD = 4'h8;
  localparam logic [3:0] POS_RFID     = 4'h9;

  localparam logic [7:0] CHR_STX      = 8'h02;
  localparam logic [7:0] CHR_CR       = 8'h0D;
  localparam logic [7:0] CHR_LF       = 8'h0A;
  localparam logic [7:0] CHR_DC2      = 8'h12;
  localparam logic [7:0] CHR_DC4      = 8'h14;
  localparam logic [7:0] CHR_VER_UP   = 8'h56;
  localparam logic [7:0] CHR_VER_LO   = 8'h76;
  localparam logic [7:0] CHR_PLUS     = 8'h2B;
  localparam logic [7:0] CHR_MINUS    = 8'h2D;
  localparam logic [7:0] CHR_DEFAULTS = 8'h52;
  localparam logic [7:0] CHR_RESTART  = 8'h48;

  localparam int NUM_CMDS = 5;
  localparam int PEND_VER      = 0;
  localparam int PEND_GATE_ON  = 1;
  localparam int PEND_GATE_OFF = 2;
  localparam int PEND_DEFAULTS = 3;
  localparam int PEND_RESTART  = 4;

  typedef enum logic [2:0] {FR_IDLE, FR_STX, FR_CHAR, FR_CR, FR_LF} scg_frame_state_t;

  // Positions at which command mode exists.
  function automatic logic scg_cmd_pos(input logic [3:0] pos);
    scg_cmd_pos = (pos == POS_2D_GATE) || (pos == POS_2D_TRIG) || (pos == POS_RFID);
  endfunction : scg_cmd_pos

  // Telegrams carry a leading STX at every position but the hand-held one.
  function automatic logic scg_has_stx(input logic [3:0] pos);
    scg_has_stx = (pos != POS_HANDHELD);
  endfunction : scg_has_stx

  // Command character for a pending command at a position.
  function automatic logic [7:0] scg_cmd_char(input logic [3:0] pos, input int idx);
    scg_cmd_char = CHR_VER_UP;
    case (idx)
      PEND_VER: begin
        scg_cmd_char = (pos == POS_RFID) ? CHR_VER_LO : CHR_VER_UP;
      end
      PEND_GATE_ON: begin
        scg_cmd_char = (pos == POS_2D_GATE) ? CHR_DC2 : CHR_PLUS;
      end
      PEND_GATE_OFF: begin
        scg_cmd_char = (pos == POS_2D_GATE) ? CHR_DC4 : CHR_MINUS;
      end
      PEND_DEFAULTS: begin
        scg_cmd_char = CHR_DEFAULTS;
      end
      default: begin
        scg_cmd_char = CHR_RESTART;
      end
    endcase
  endfunction : scg_cmd_char

endpackage : scg_pkg

// file: logic/scg_stream_if.sv
// Purpose: Byte stream with valid and ready between gateway modules.
// Assumes: A word moves on a clock edge where valid and ready are both high.
// Notes:   The source holds data and valid until the word is taken.
`timescale 1ns/1ps
interface scg_stream_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : scg_stream_if

// file: logic/scg_pair_buffer.sv
// Purpose: Two-entry buffer between the telegram builder and the serial transmitter.
// Assumes: Both sides share one clock.
// Notes:   Full and empty are exact, so a stalled drain stalls the filler.
`timescale 1ns/1ps
module scg_pair_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  // Stream sides.
  scg_stream_if.snk fill_in,
  scg_stream_if.src drain_out
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [PW-1:0]    wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [PW:0]      count, next_count;
  logic             push, pop;

  always_comb begin
    fill_in.ready   = (count != (PW+1)'(DEPTH));
    drain_out.valid = (count != '0);
    drain_out.data  = mem[rd_ptr];
    push            = fill_in.valid && fill_in.ready;
    pop             = drain_out.valid && drain_out.ready;
    next_mem        = mem;
    next_wr_ptr     = wr_ptr;
    next_rd_ptr     = rd_ptr;
    if (push) begin
      next_mem[wr_ptr] = fill_in.data;
      next_wr_ptr      = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

endmodule : scg_pair_buffer

// file: logic/scg_gateway.sv
// Purpose: Turns control bits written over APB into framed ASCII commands on a serial line.
// Assumes: The switch position input is synchronous and stable while a telegram is built.
// Notes:   Commands are sent one telegram each, lowest pending command first.
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module scg_gateway #(
  parameter int BIT_CYCLES = scg_pkg::BIT_CYCLES
) (
  // Clock and reset.
  input  wire logic        ref_clk_in,
  input  wire logic        reset_in,
  // APB slave.
  input  wire logic        apb_psel_in,
  input  wire logic        apb_penable_in,
  input  wire logic        apb_pwrite_in,
  input  wire logic [7:0]  apb_paddr_in,
  input  wire logic [31:0] apb_pwdata_in,
  output logic      [31:0] apb_prdata_out,
  output logic             apb_pready_out,
  output logic             apb_pslverr_out,
  // Device type switch.
  input  wire logic [3:0]  device_type_switch_in,
  // Serial line.
  output logic             serial_txd_out
);
  import scg_pkg::*;

  localparam int BW = $clog2(BIT_CYCLES);
  localparam logic [BW-1:0] BIT_LAST = BW'(BIT_CYCLES - 1);

  // Status word as software reads it.
  function automatic logic [31:0] scg_status_word(input logic [3:0] pos, input logic bsy, input logic txa,
                                                  input logic [7:0] cnt);
    scg_status_word                                  = '0;
    scg_status_word[3:0]                             = pos;
    scg_status_word[STAT_BUSY_BIT]                   = bsy;
    scg_status_word[STAT_TX_BIT]                     = txa;
    scg_status_word[STAT_COUNT_LSB+7:STAT_COUNT_LSB] = cnt;
  endfunction : scg_status_word

  // One-hot mask of the lowest pending command.
  function automatic logic [NUM_CMDS-1:0] scg_lowest_one(input logic [NUM_CMDS-1:0] req);
    scg_lowest_one = '0;
    for (int i = NUM_CMDS - 1; i >= 0; i--) begin
      if (req[i]) begin
        scg_lowest_one = NUM_CMDS'(1) << i;
      end
    end
  endfunction : scg_lowest_one

  scg_stream_if #(.WIDTH(8)) fill_bus ();
  scg_stream_if #(.WIDTH(8)) drain_bus ();

  scg_pair_buffer #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_buffer (
    .ref_clk_in (ref_clk_in),
    .reset_in   (reset_in),
    .fill_in    (fill_bus.snk),
    .drain_out  (drain_bus.src)
  );

  // Register file and APB answer.
  logic [1:0]  ctrl;
  logic [1:0]  next_ctrl;
  logic [15:0] cmd;
  logic [15:0] next_cmd;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        access;
  logic        write_now;
  logic        busy;
  logic        tx_active;
  logic [7:0]  frames;
  logic [7:0]  next_frames;

  always_comb begin
    access       = apb_psel_in && apb_penable_in && !apb_pready_out;
    write_now    = apb_psel_in && apb_penable_in && apb_pwrite_in && apb_pready_out;
    next_ctrl    = ctrl;
    next_cmd     = cmd;
    next_prdata  = apb_prdata_out;
    next_pready  = access;
    next_pslverr = 1'b0;
    if (access) begin
      next_prdata = '0;
      case (apb_paddr_in)
        ADDR_CTRL: begin
          next_prdata[1:0] = ctrl;
        end
        ADDR_CMD: begin
          next_prdata[15:0] = cmd;
        end
        ADDR_STATUS: begin
          next_prdata = scg_status_word(device_type_switch_in, busy, tx_active, frames);
        end
        default: begin
          next_pslverr = 1'b1;
        end
      endcase
    end
    // A write lands at the edge where the master sees pready high.
    if (write_now) begin
      case (apb_paddr_in)
        ADDR_CTRL: begin
          next_ctrl = apb_pwdata_in[1:0];
        end
        ADDR_CMD: begin
          next_cmd = apb_pwdata_in[15:0];
        end
        default: begin
          next_cmd = cmd;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl            <= CTRL_RESET;
      cmd             <= CMD_RESET;
      apb_prdata_out  <= '0;
      apb_pready_out  <= 1'b0;
      apb_pslverr_out <= 1'b0;
    end else begin
      ctrl            <= next_ctrl;
      cmd             <= next_cmd;
      apb_prdata_out  <= next_prdata;
      apb_pready_out  <= next_pready;
      apb_pslverr_out <= next_pslverr;
    end
  end

  // Control bit edges become pending commands.
  logic [15:0]         cmd_prev;
  logic [15:0]         rise;
  logic [15:0]         fall;
  logic [NUM_CMDS-1:0] pending;
  logic [NUM_CMDS-1:0] next_pending;
  logic [NUM_CMDS-1:0] events;
  logic [NUM_CMDS-1:0] take;
  logic                cmd_ok;
  logic                pos_rfid;
  logic                uhf;

  always_comb begin
    pos_rfid = (device_type_switch_in == POS_RFID);
    uhf      = ctrl[CTRL_UHF_BIT];
    cmd_ok   = ctrl[CTRL_CMD_MODE_BIT] && scg_cmd_pos(device_type_switch_in);
    rise     = cmd & ~cmd_prev;
    fall     = ~cmd & cmd_prev;
    events   = '0;
    events[PEND_VER]      = rise[CMD_VER_BIT] && !(pos_rfid && uhf);
    events[PEND_GATE_ON]  = rise[CMD_GATE_BIT];
    events[PEND_GATE_OFF] = fall[CMD_GATE_BIT] && (device_type_switch_in != POS_2D_TRIG);
    events[PEND_DEFAULTS] = rise[CMD_RESET_BIT] && pos_rfid && !uhf;
    events[PEND_RESTART]  = rise[CMD_RESTART_BIT] && pos_rfid;
    if (cmd_ok) begin
      next_pending = (pending & ~take) | events;
    end else begin
      next_pending = '0;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cmd_prev <= CMD_RESET;
      pending  <= '0;
    end else begin
      cmd_prev <= cmd;
      pending  <= next_pending;
    end
  end

  // Telegram builder feeding the buffer.
  scg_frame_state_t    state;
  scg_frame_state_t    next_state;
  logic [7:0]          payload;
  logic [7:0]          next_payload;

  always_comb begin
    next_state     = state;
    next_payload   = payload;
    next_frames    = frames;
    take           = '0;
    fill_bus.valid = 1'b0;
    fill_bus.data  = CHR_STX;
    case (state)
      FR_IDLE: begin
        take = scg_lowest_one(pending);
        for (int i = 0; i < NUM_CMDS; i++) begin
          if (take[i]) begin
            next_payload = scg_cmd_char(device_type_switch_in, i);
          end
        end
        if (|pending) begin
          next_state = scg_has_stx(device_type_switch_in) ? FR_STX : FR_CHAR;
        end
      end
      FR_STX: begin
        fill_bus.valid = 1'b1;
        fill_bus.data  = CHR_STX;
        if (fill_bus.ready) begin
          next_state = FR_CHAR;
        end
      end
      FR_CHAR: begin
        fill_bus.valid = 1'b1;
        fill_bus.data  = payload;
        if (fill_bus.ready) begin
          next_state = FR_CR;
        end
      end
      FR_CR: begin
        fill_bus.valid = 1'b1;
        fill_bus.data  = CHR_CR;
        if (fill_bus.ready) begin
          next_state = FR_LF;
        end
      end
      FR_LF: begin
        fill_bus.valid = 1'b1;
        fill_bus.data  = CHR_LF;
        if (fill_bus.ready) begin
          next_state  = FR_IDLE;
          next_frames = frames + 8'h01;
        end
      end
      default: begin
        next_state = FR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state   <= FR_IDLE;
      payload <= '0;
      frames  <= '0;
    end else begin
      state   <= next_state;
      payload <= next_payload;
      frames  <= next_frames;
    end
  end

  // Serial transmitter, 8N1 at the bit rate, draining the buffer.
  logic [9:0]    tx_shift;
  logic [9:0]    next_tx_shift;
  logic [3:0]    tx_bits;
  logic [3:0]    next_tx_bits;
  logic [BW-1:0] tx_baud;
  logic [BW-1:0] next_tx_baud;
  logic          next_txd;

  always_comb begin
    drain_bus.ready = (tx_bits == 4'h0);
    tx_active       = (tx_bits != 4'h0);
    busy            = (|pending) || (state != FR_IDLE) || drain_bus.valid || tx_active;
  end

  always_comb begin
    next_tx_shift   = tx_shift;
    next_tx_bits    = tx_bits;
    next_tx_baud    = tx_baud;
    next_txd        = serial_txd_out;
    if (tx_bits == 4'h0) begin
      next_txd = 1'b1;
      if (drain_bus.valid) begin
        next_tx_shift = {1'b1, drain_bus.data, 1'b0};
        next_tx_bits  = UART_FRAME_BITS;
        next_tx_baud  = BIT_LAST;
        next_txd      = 1'b0;
      end
    end else if (tx_baud == '0) begin
      next_tx_shift = {1'b1, tx_shift[9:1]};
      next_tx_bits  = tx_bits - 4'h1;
      next_tx_baud  = BIT_LAST;
      next_txd      = next_tx_shift[0];
    end else begin
      next_tx_baud = tx_baud - BW'(1);
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_shift       <= 10'h3FF;
      tx_bits        <= 4'h0;
      tx_baud        <= '0;
      serial_txd_out <= 1'b1;
    end else begin
      tx_shift       <= next_tx_shift;
      tx_bits        <= next_tx_bits;
      tx_baud        <= next_tx_baud;
      serial_txd_out <= next_txd;
    end
  end

endmodule : scg_gateway

// file: verification/scg_gateway_assertions.sv
// Purpose: Port assertions of the serial command gateway.
// Assumes: One clock domain with an asynchronous active-high reset.
// Notes:   Bound into every gateway instance.
`timescale 1ns/1ps
module scg_gateway_assertions #(
  parameter int BIT_CYCLES = 8
) (
  // Clock and reset.
  input wire logic        ref_clk_in,
  input wire logic        reset_in,
  // APB.
  input wire logic        apb_psel_in,
  input wire logic        apb_penable_in,
  input wire logic        apb_pwrite_in,
  input wire logic [7:0]  apb_paddr_in,
  input wire logic [31:0] apb_pwdata_in,
  input wire logic [31:0] apb_prdata_out,
  input wire logic        apb_pready_out,
  input wire logic        apb_pslverr_out,
  // Switch and serial line.
  input wire logic [3:0]  device_type_switch_in,
  input wire logic        serial_txd_out
);
  logic        acc;
  logic        map;
  logic        txd_q;
  logic [15:0] run_len;
  logic [15:0] next_run_len;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  assign acc = apb_psel_in && apb_penable_in;
  assign map = apb_paddr_in == 8'h00 || apb_paddr_in == 8'h04 || apb_paddr_in == 8'h08;
  // Counts the cycles the line has held its present level.
  always_comb begin
    next_run_len = (serial_txd_out != txd_q) ? 16'h0001 : run_len + {15'h0000, run_len != 16'hFFFF};
  end
  always_ff @(posedge ref_clk_in or posedge reset_in) begin
    if (reset_in) begin
      txd_q   <= 1'b1;
      run_len <= 16'hFFFF;
    end else begin
      txd_q   <= serial_txd_out;
      run_len <= next_run_len;
    end
  end
  property p_rdy_lat; acc && !apb_pready_out |=> apb_pready_out ##1 !apb_pready_out; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("pready not one cycle after access");
  property p_rdy_idle; !acc |=> !apb_pready_out; endproperty
  a_rdy_idle: assert property (p_rdy_idle) else $error("pready without access");
  property p_err_unm; apb_pready_out && !map |-> apb_pslverr_out; endproperty
  a_err_unm: assert property (p_err_unm) else $error("unmapped access without error");
  property p_err_map; apb_pready_out && map |-> !apb_pslverr_out; endproperty
  a_err_map: assert property (p_err_map) else $error("mapped access with error");
  property p_rd_zero; apb_pready_out && !map && !apb_pwrite_in |-> apb_prdata_out == 32'h0; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
  property p_stat; apb_pready_out && !apb_pwrite_in && apb_paddr_in == 8'h08
    |-> apb_prdata_out[3:0] == device_type_switch_in; endproperty
  a_stat: assert property (p_stat) else $error("status switch field wrong");
  property p_rd_hold; !acc |=> $stable(apb_prdata_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed between accesses");
  property p_bit_len; serial_txd_out != txd_q |-> run_len >= BIT_CYCLES; endproperty
  a_bit_len: assert property (p_bit_len) else $error("line level shorter than one bit");
  property p_rst_idle; $fell(reset_in) |-> serial_txd_out && !apb_pready_out; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("line not idle after reset");
  c_write: cover property (acc && apb_pwrite_in && apb_pready_out);
  c_err: cover property (apb_pready_out && apb_pslverr_out);
  c_start: cover property ($fell(serial_txd_out));
endmodule : scg_gateway_assertions
bind scg_gateway scg_gateway_assertions #(.BIT_CYCLES(BIT_CYCLES)) u_scg_chk (
  .ref_clk_in(ref_clk_in), .reset_in(reset_in), .apb_psel_in(apb_psel_in), .apb_penable_in(apb_penable_in),
  .apb_pwrite_in(apb_pwrite_in), .apb_paddr_in(apb_paddr_in), .apb_pwdata_in(apb_pwdata_in),
  .apb_prdata_out(apb_prdata_out), .apb_pready_out(apb_pready_out), .apb_pslverr_out(apb_pslverr_out),
  .device_type_switch_in(device_type_switch_in), .serial_txd_out(serial_txd_out));

// file: verification/scg_serial_reader.sv
// Purpose: Reader model that receives the bytes the gateway sends.
// Assumes: Idle high line, 8 data bits LSB first, no parity, one stop bit.
// Notes:   Samples mid-bit, so it never races the line's own edges.
`timescale 1ns/1ps
module scg_serial_reader #(
  parameter int BIT_CYCLES = 8
) (
  // Clock and line.
  input  wire logic  ref_clk_in,
  input  wire logic  rxd_in,
  // Received bytes.
  output logic [7:0] byte_out,
  output logic       strobe_out,
  output logic       stop_err_out
);
  int k;
  initial begin
    byte_out = 8'h00;
    strobe_out = 1'b0;
    stop_err_out = 1'b0;
    forever begin
      @(negedge rxd_in);
      strobe_out = 1'b0;
      repeat (BIT_CYCLES / 2) @(posedge ref_clk_in);
      for (k = 0; k < 8; k++) begin
        repeat (BIT_CYCLES) @(posedge ref_clk_in);
        byte_out[k] = rxd_in;
      end
      repeat (BIT_CYCLES) @(posedge ref_clk_in);
      stop_err_out = stop_err_out | (rxd_in !== 1'b1);
      strobe_out = 1'b1;
    end
  end
endmodule : scg_serial_reader

// file: verification/testbench.sv
// Purpose: Self-checking bench of the serial command gateway.
// Assumes: BIT_CYCLES is 8, so one byte takes 80 clocks.
// Notes:   Each row sets position, control and command bits and lists the telegrams.
`timescale 1ns/1ps
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, x); end end
module testbench;
  import scg_pkg::*;
  localparam int BC = 8;
  typedef struct packed {logic [3:0] pos; logic [1:0] ctrl; logic [15:0] cmd; logic [2:0] n; logic [31:0] c;} scg_row_t;
  // Characters of the expected telegrams, first one in the lowest byte.
  localparam scg_row_t ROWS [15] = '{
    '{4'h6, 2'h1, 16'h0001, 3'h1, 32'h56},
    '{4'h6, 2'h1, 16'h0003, 3'h1, 32'h12},
    '{4'h6, 2'h1, 16'h0001, 3'h1, 32'h14},
    '{4'h6, 2'h1, 16'h4001, 3'h0, 32'h0},
    '{4'h6, 2'h0, 16'h0000, 3'h0, 32'h0},
    '{4'h6, 2'h0, 16'h0001, 3'h0, 32'h0},
    '{4'h7, 2'h1, 16'h0000, 3'h0, 32'h0},
    '{4'h7, 2'h1, 16'h0003, 3'h2, 32'h2B56},
    '{4'h7, 2'h1, 16'h0000, 3'h0, 32'h0},
    '{4'h9, 2'h1, 16'hC003, 3'h4, 32'h48522B76},
    '{4'h9, 2'h1, 16'h0000, 3'h1, 32'h2D},
    '{4'h9, 2'h3, 16'h4001, 3'h0, 32'h0},
    '{4'h9, 2'h3, 16'hC003, 3'h2, 32'h482B},
    '{4'h9, 2'h3, 16'h0000, 3'h1, 32'h2D},
    '{4'h8, 2'h1, 16'hC003, 3'h0, 32'h0}
  };
  logic        ref_clk_in, reset_in, psel, pen, pw, pready, pslverr, txd, rx_stb, rx_err;
  logic [7:0]  pa, rx_byte, got, exp_b, tg;
  logic [31:0] pd, prdata;
  logic [3:0]  sw;
  logic [7:0]  rxq [$];
  int          err_total, cmp_count, r, t, b, k;
  scg_gateway #(.BIT_CYCLES(BC)) dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .apb_psel_in(psel),
    .apb_penable_in(pen), .apb_pwrite_in(pw), .apb_paddr_in(pa), .apb_pwdata_in(pd), .apb_prdata_out(prdata),
    .apb_pready_out(pready), .apb_pslverr_out(pslverr), .device_type_switch_in(sw), .serial_txd_out(txd));
  scg_serial_reader #(.BIT_CYCLES(BC)) u_reader (.ref_clk_in(ref_clk_in), .rxd_in(txd), .byte_out(rx_byte),
    .strobe_out(rx_stb), .stop_err_out(rx_err));
  always #5 ref_clk_in = ~ref_clk_in;
  always @(posedge rx_stb) rxq.push_back(rx_byte);
  // One APB transfer; the answer is taken at the rising edge where pready is sampled high.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x, input logic xe);
    int n;
    @(posedge ref_clk_in);
    psel <= 1'b1;
    pen <= 1'b0;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge ref_clk_in);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready !== 1'b1 && n < 50);
    `CHK(n < 50, 1'b1)
    if (!w) `CHK(prdata, x)
    `CHK(pslverr, xe)
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : acc
  task test_done;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  initial begin
    #300000;
    err_total++;
    $display("[FAIL] %0t run did not finish", $time);
    test_done();
  end
  initial begin
    ref_clk_in = 1'b0;
    reset_in = 1'b1;
    {psel, pen, pw, pa, pd} = '0;
    sw = 4'h6;
    err_total = 0;
    cmp_count = 0;
    tg = 8'h00;
    repeat (4) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(posedge ref_clk_in);
    `CHK(txd, 1'b1)
    acc(1'b0, 8'h00, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 8'h04, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 8'h08, 32'h0, 32'h6, 1'b0);
    acc(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 8'h10, 32'hFFFFFFFF, 32'h0, 1'b1);
    $display("test 0 done");
    for (r = 0; r < 15; r++) begin
      @(posedge ref_clk_in);
      sw <= ROWS[r].pos;
      acc(1'b1, 8'h00, {30'h0, ROWS[r].ctrl}, 32'h0, 1'b0);
      acc(1'b1, 8'h04, {16'h0, ROWS[r].cmd}, 32'h0, 1'b0);
      repeat (4) @(posedge ref_clk_in);
      acc(1'b0, 8'h08, 32'h0, {16'h0, tg, (ROWS[r].n != 3'h0) ? 4'h3 : 4'h0, ROWS[r].pos}, 1'b0);
      for (t = 0; t < ROWS[r].n; t++) begin
        for (b = 0; b < 4; b++) begin
          k = 0;
          while (rxq.size() == 0 && k < 400) begin
            @(posedge ref_clk_in);
            k++;
          end
          got = (rxq.size() > 0) ? rxq.pop_front() : 8'h00;
          exp_b = (b == 0) ? 8'h02 : (b == 1) ? ROWS[r].c[8*t +: 8] : (b == 2) ? 8'h0D : 8'h0A;
          `CHK(got, exp_b)
        end
      end
      repeat (60 * BC) @(posedge ref_clk_in);
      `CHK(rxq.size(), 0)
      tg = tg + {5'h00, ROWS[r].n};
      $display("test %0d done", r + 1);
    end
    acc(1'b1, 8'h08, 32'hFFFFFFFF, 32'h0, 1'b0);
    acc(1'b0, 8'h08, 32'h0, 32'h00000D08, 1'b0);
    acc(1'b0, 8'h00, 32'h0, 32'h1, 1'b0);
    acc(1'b0, 8'h04, 32'h0, 32'h0000C003, 1'b0);
    `CHK(rx_err, 1'b0)
    $display("test 16 done");
    test_done();
  end
endmodule : testbench
